//--- src/snt_tx.sv
// single-wire nibble link transmit engine with register port
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "snt_defs.svh"

module snt_tx
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic [2:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        sent_rx_in,
   output logic             sent_tx_out,
   output logic             sent_tx_oe,
   output logic             frame_done
);

   snt_pkg::snt_state_s s_r;
   snt_pkg::snt_state_s s_nxt;

   // ----------------------------------------------------------------
   // control decode
   // ----------------------------------------------------------------
   logic       en;
   logic       rx_mode;
   logic       sync_mode;
   logic       hw_crc;
   logic       pause_en;
   logic [2:0] nib_n;
   logic       tick;
   logic [31:0] dat;
   logic [3:0] crc_hw;
   logic [3:0] crc_nib;
   logic [11:0] frame_lim;
   logic [11:0] elapsed;
   logic [11:0] pause_len;
   logic       start_req;
   logic       pulse_end;
   logic [11:0] pc_next;
   logic       status_bit;

   assign en        = s_r.ctl[`SNT_BIT_MODULE_ENABLE];
   assign rx_mode   = s_r.ctl[`SNT_BIT_RECEIVE_SEL];
   assign sync_mode = s_r.ctl[`SNT_BIT_TX_MODE_SEL];
   assign hw_crc    = s_r.ctl[`SNT_BIT_HW_CRC_SEL];
   assign pause_en  = s_r.ctl[`SNT_BIT_PAUSE_ENABLE];
   // zero or out-of-range counts are clamped to the legal 1..6 range
   assign nib_n = (s_r.ctl[`SNT_NIB_CNT_HI:`SNT_NIB_CNT_LO] == 3'h0) ? 3'h1 :
                  (s_r.ctl[`SNT_NIB_CNT_HI:`SNT_NIB_CNT_LO] > `SNT_MAX_NIBBLES) ?
                  `SNT_MAX_NIBBLES : s_r.ctl[`SNT_NIB_CNT_HI:`SNT_NIB_CNT_LO];

   assign tick = (s_r.tick_cnt == s_r.tick_per);
   // status nibble on top, data nibbles below it, crc in the low nibble
   assign dat  = {s_r.dat_hi, s_r.dat_lo};

   // ----------------------------------------------------------------
   // crc over the data nibbles, then one zero nibble of augmentation
   // ----------------------------------------------------------------
   // shift-in form: the nibble enters the register, so the closing zero
   // nibble is the only augmentation and the seed is not shifted twice
   function automatic logic [3:0] crc_step(input logic [3:0] c, input logic [3:0] n);
      logic [3:0] r;
      r = c;
      for (int b = 3; b >= 0; b--)
      begin
         r = {r[2:0], n[b]} ^ (r[3] ? `SNT_CRC_POLY : 4'h0);
      end
      return r;
   endfunction

   always_comb
   begin
      logic [3:0] c;
      c = `SNT_CRC_SEED;
      for (int k = 1; k <= 6; k++)
      begin
         if (3'(k) <= nib_n)
         begin
            c = crc_step(c, dat[31-4*k -: 4]);
         end
      end
      crc_hw = crc_step(c, 4'h0);
   end

   assign crc_nib = hw_crc ? crc_hw : s_r.dat_lo[3:0];

   // ----------------------------------------------------------------
   // pause length
   // ----------------------------------------------------------------
   assign frame_lim = (s_r.frame_per > {4'h0, `SNT_FRAME_MAX_TICKS}) ?
                      `SNT_FRAME_MAX_TICKS : s_r.frame_per[11:0];
   assign elapsed   = s_r.frame_ticks + 12'h001;
   // pause is computed at the last tick of the crc pulse
   always_comb
   begin
      pause_len = `SNT_PAUSE_MIN_TICKS;
      if (!sync_mode && frame_lim > elapsed &&
          (frame_lim - elapsed) > `SNT_PAUSE_MIN_TICKS)
      begin
         pause_len = frame_lim - elapsed;
      end
   end

   assign pulse_end = tick && (s_r.pulse_cnt == s_r.pulse_len - 12'h001);
   assign pc_next   = s_r.pulse_cnt + 12'h001;

   // sync trigger only counts while transmit, enabled and idle
   assign start_req = reg_wr && reg_addr == `SNT_OFS_LINK_STATUS &&
                      reg_wdata[`SNT_BIT_SYNC_SEND] && !rx_mode &&
                      sync_mode && en && !s_r.busy;

   always_comb
   begin
      if (rx_mode)
      begin
         status_bit = s_r.rx_sync;
      end
      else if (!sync_mode)
      begin
         status_bit = en;
      end
      else
      begin
         status_bit = s_r.busy;
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic go;
      s_nxt = s_r;
      go    = 1'b0;
      s_nxt.done    = 1'b0;
      s_nxt.rd_data = 16'h0000;

      // register writes
      if (reg_wr)
      begin
         case (reg_addr)
            `SNT_OFS_MAIN_CONTROL: s_nxt.ctl = reg_wdata & `SNT_CTL_WR_MASK;
            `SNT_OFS_TICK_PERIOD:  s_nxt.tick_per = reg_wdata;
            `SNT_OFS_FRAME_PERIOD: s_nxt.frame_per = reg_wdata;
            `SNT_OFS_DATA_LOW:     s_nxt.dat_lo = reg_wdata;
            `SNT_OFS_DATA_HIGH:    s_nxt.dat_hi = reg_wdata;
            default:               s_nxt.ctl = s_r.ctl;
         endcase
      end

      // register reads, answer in the following cycle only
      if (reg_rd)
      begin
         case (reg_addr)
            `SNT_OFS_MAIN_CONTROL: s_nxt.rd_data = s_r.ctl;
            `SNT_OFS_TICK_PERIOD:  s_nxt.rd_data = s_r.tick_per;
            `SNT_OFS_FRAME_PERIOD: s_nxt.rd_data = s_r.frame_per;
            `SNT_OFS_DATA_LOW:     s_nxt.rd_data = s_r.dat_lo;
            `SNT_OFS_DATA_HIGH:    s_nxt.rd_data = s_r.dat_hi;
            `SNT_OFS_LINK_STATUS:  s_nxt.rd_data = {15'h0000, status_bit};
            default:               s_nxt.rd_data = 16'h0000;
         endcase
      end

      // tick divider runs whenever the module is enabled
      s_nxt.tick_cnt = (tick || !en) ? 16'h0000 : s_r.tick_cnt + 16'h0001;

      // receive side: sync detect on falling-edge spacing
      s_nxt.rx_s1   = sent_rx_in;
      s_nxt.rx_s2   = s_r.rx_s1;
      s_nxt.rx_prev = s_r.rx_s2;
      if (!en || !rx_mode)
      begin
         s_nxt.rx_cnt  = 7'h00;
         s_nxt.rx_sync = 1'b0;
      end
      else if (s_r.rx_prev && !s_r.rx_s2)
      begin
         if (s_r.rx_cnt >= `SNT_RX_SYNC_MIN && s_r.rx_cnt <= `SNT_RX_SYNC_MAX)
         begin
            s_nxt.rx_sync = 1'b1;
         end
         else if (s_r.rx_cnt < `SNT_RX_NIB_MIN || s_r.rx_cnt > `SNT_RX_NIB_MAX)
         begin
            s_nxt.rx_sync = 1'b0;
         end
         s_nxt.rx_cnt = 7'h00;
      end
      else if (tick)
      begin
         if (s_r.rx_cnt == `SNT_RX_CNT_MAX)
         begin
            s_nxt.rx_sync = 1'b0;
         end
         else
         begin
            s_nxt.rx_cnt = s_r.rx_cnt + 7'h01;
         end
      end

      // transmit sequencer
      if (!en || rx_mode)
      begin
         s_nxt.st        = snt_pkg::SNT_IDLE;
         s_nxt.busy      = 1'b0;
         s_nxt.pulse_cnt = 12'h000;
      end
      else
      begin
         case (s_r.st)
            snt_pkg::SNT_IDLE:
            begin
               go = !sync_mode || start_req;
            end
            snt_pkg::SNT_SYNC, snt_pkg::SNT_NIB, snt_pkg::SNT_PAUSE:
            begin
               if (tick)
               begin
                  s_nxt.pulse_cnt   = pc_next;
                  s_nxt.frame_ticks = s_r.frame_ticks + 12'h001;
               end
               if (pulse_end)
               begin
                  s_nxt.pulse_cnt = 12'h000;
                  if (s_r.st == snt_pkg::SNT_SYNC)
                  begin
                     s_nxt.st        = snt_pkg::SNT_NIB;
                     s_nxt.nib_idx   = 3'h0;
                     s_nxt.pulse_len = `SNT_NIB_BASE_TICKS + {8'h00, dat[31:28]};
                  end
                  else if (s_r.st == snt_pkg::SNT_NIB && s_r.nib_idx < nib_n)
                  begin
                     s_nxt.nib_idx   = s_r.nib_idx + 3'h1;
                     s_nxt.pulse_len = `SNT_NIB_BASE_TICKS +
                                       {8'h00, dat[27 - 4*s_r.nib_idx -: 4]};
                  end
                  else if (s_r.st == snt_pkg::SNT_NIB && s_r.nib_idx == nib_n)
                  begin
                     s_nxt.nib_idx   = `SNT_CRC_INDEX;
                     s_nxt.pulse_len = `SNT_NIB_BASE_TICKS + {8'h00, crc_nib};
                  end
                  else if (s_r.st == snt_pkg::SNT_NIB && pause_en)
                  begin
                     s_nxt.st        = snt_pkg::SNT_PAUSE;
                     s_nxt.pulse_len = pause_len;
                  end
                  else
                  begin
                     s_nxt.done = 1'b1;
                     s_nxt.busy = 1'b0;
                     s_nxt.st   = snt_pkg::SNT_IDLE;
                     go         = !sync_mode;
                  end
               end
            end
            default:
            begin
               s_nxt.st = snt_pkg::SNT_IDLE;
            end
         endcase
      end

      if (go)
      begin
         s_nxt.st          = snt_pkg::SNT_SYNC;
         s_nxt.busy        = 1'b1;
         s_nxt.pulse_cnt   = 12'h000;
         s_nxt.pulse_len   = `SNT_SYNC_TICKS;
         s_nxt.frame_ticks = 12'h000;
         s_nxt.tick_cnt    = 16'h0000;
      end

      // pin: low for the first ticks of each pulse, idle high
      s_nxt.tx_oe  = en && !rx_mode;
      s_nxt.tx_out = (s_nxt.st == snt_pkg::SNT_IDLE) ||
                     (s_nxt.pulse_cnt >= `SNT_LOW_TICKS);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_r           <= '0;
         s_r.ctl       <= `SNT_RST_REG;
         s_r.tx_out    <= 1'b1;
         s_r.rx_s1     <= 1'b1;
         s_r.rx_s2     <= 1'b1;
         s_r.rx_prev   <= 1'b1;
         s_r.pulse_len <= `SNT_SYNC_TICKS;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata   = s_r.rd_data;
   assign sent_tx_out = s_r.tx_out;
   assign sent_tx_oe  = s_r.tx_oe;
   assign frame_done  = s_r.done;

endmodule

//--- src/snt_defs.svh
// register offsets, field positions, reset values and counts for the transmit engine
`ifndef SNT_DEFS_SVH
`define SNT_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define SNT_OFS_MAIN_CONTROL   3'h0
`define SNT_OFS_TICK_PERIOD    3'h1
`define SNT_OFS_FRAME_PERIOD   3'h2
`define SNT_OFS_DATA_LOW       3'h3
`define SNT_OFS_DATA_HIGH      3'h4
`define SNT_OFS_LINK_STATUS    3'h5

// ----------------------------------------------------------------
// main_control fields and write mask; SNT_BIT_SYNC_SEND is in the link status word
// ----------------------------------------------------------------
`define SNT_BIT_MODULE_ENABLE  15
`define SNT_BIT_RECEIVE_SEL    11
`define SNT_BIT_TX_MODE_SEL    10
`define SNT_BIT_HW_CRC_SEL     8
`define SNT_BIT_PAUSE_ENABLE   7
`define SNT_NIB_CNT_HI         2
`define SNT_NIB_CNT_LO         0
`define SNT_CTL_WR_MASK        16'h8D87
`define SNT_BIT_SYNC_SEND      0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SNT_RST_REG            16'h0000

// ----------------------------------------------------------------
// pulse timing in ticks, nibble count limits and crc constants
// ----------------------------------------------------------------
`define SNT_SYNC_TICKS         12'h038
`define SNT_NIB_BASE_TICKS     12'h00C
`define SNT_LOW_TICKS          12'h005
`define SNT_PAUSE_MIN_TICKS    12'h00C
`define SNT_FRAME_MAX_TICKS    12'h7FF
`define SNT_MAX_NIBBLES        3'h6
`define SNT_CRC_INDEX          3'h7
`define SNT_CRC_SEED           4'h5
`define SNT_CRC_POLY           4'hD

// ----------------------------------------------------------------
// receive sync window and nibble window in ticks
// ----------------------------------------------------------------
`define SNT_RX_SYNC_MIN        7'h37
`define SNT_RX_SYNC_MAX        7'h39
`define SNT_RX_NIB_MIN         7'h0C
`define SNT_RX_NIB_MAX         7'h1B
`define SNT_RX_CNT_MAX         7'h7F

`endif

//--- src/snt_pkg.sv
// types shared by the transmit engine
package snt_pkg;

   typedef enum logic [1:0] {
      SNT_IDLE  = 2'b00,
      SNT_SYNC  = 2'b01,
      SNT_NIB   = 2'b10,
      SNT_PAUSE = 2'b11
   } snt_state_e;

   typedef struct packed {
      logic [15:0] ctl;
      logic [15:0] tick_per;
      logic [15:0] frame_per;
      logic [15:0] dat_lo;
      logic [15:0] dat_hi;
      logic [15:0] tick_cnt;
      snt_state_e  st;
      logic [2:0]  nib_idx;
      logic [11:0] pulse_cnt;
      logic [11:0] pulse_len;
      logic [11:0] frame_ticks;
      logic        busy;
      logic        tx_out;
      logic        tx_oe;
      logic        done;
      logic [15:0] rd_data;
      logic        rx_s1;
      logic        rx_s2;
      logic        rx_prev;
      logic [6:0]  rx_cnt;
      logic        rx_sync;
   } snt_state_s;

endpackage

//--- verif/snt_tx_checker.sv
// port checker for the transmit engine
`timescale 1ns/10ps
`include "snt_defs.svh"

module snt_tx_checker
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic [2:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        sent_rx_in,
   input  wire logic        sent_tx_out,
   input  wire logic        sent_tx_oe,
   input  wire logic        frame_done
);
   // ----
   // shadow of control writes and pin timing
   // ----
   logic        en_r;
   logic        rx_r;
   logic        mode_r;
   logic        out_q;
   logic [15:0] tp_r;
   logic [15:0] gap_r;
   logic [19:0] tick_w;

   assign tick_w = {4'h0, tp_r} + 20'h00001;

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         en_r   <= 1'b0;
         rx_r   <= 1'b0;
         mode_r <= 1'b0;
         out_q  <= 1'b1;
         tp_r   <= 16'h0000;
         gap_r  <= 16'hFFFF;
      end
      else
      begin
         if (reg_wr && reg_addr == `SNT_OFS_MAIN_CONTROL)
         begin
            en_r   <= reg_wdata[15] & ~reg_wdata[11];
            rx_r   <= reg_wdata[11];
            mode_r <= reg_wdata[10];
         end
         if (reg_wr && reg_addr == `SNT_OFS_TICK_PERIOD)
            tp_r <= reg_wdata;
         out_q <= sent_tx_out;
         // saturate so a long idle never looks like a short gap
         if (!sent_tx_oe)
            gap_r <= 16'hFFFF;
         else if (out_q && !sent_tx_out)
            gap_r <= 16'h0001;
         else if (gap_r != 16'hFFFF)
            gap_r <= gap_r + 16'h0001;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   chk_oe_rise: assert property ($rose(en_r) |-> ##[0:2] sent_tx_oe)
      else $error("output enable not raised after enable");
   chk_oe_off: assert property ((!en_r)[*3] |-> !sent_tx_oe)
      else $error("output enable high while disabled");
   chk_rx_quiet: assert property (rx_r[*3] |-> !sent_tx_oe)
      else $error("pin driven in receive direction");
   chk_idle_high: assert property (!sent_tx_oe |-> sent_tx_out)
      else $error("pin not high while released");
   chk_low_width: assert property ($rose(sent_tx_out) && sent_tx_oe
      |-> {4'h0, gap_r} == 20'h00005 * tick_w)
      else $error("low part of pulse has wrong width");
   chk_gap_min: assert property ($fell(sent_tx_out) && sent_tx_oe
      |-> {4'h0, gap_r} >= 20'h0000C * tick_w)
      else $error("pulse shorter than twelve ticks");
   chk_done_pulse: assert property (frame_done |=> !frame_done)
      else $error("frame done longer than one cycle");
   chk_done_en: assert property (frame_done |-> sent_tx_oe)
      else $error("frame done while not transmitting");
   chk_async_stat: assert property ($past(reg_rd) && $past(reg_addr) == 3'h5 && en_r
      && !mode_r |-> reg_rdata[0])
      else $error("async status bit not set while enabled");
endmodule

bind snt_tx snt_tx_checker u_snt_tx_checker
(
   .core_clk   (core_clk),
   .sys_rst    (sys_rst),
   .reg_addr   (reg_addr),
   .reg_wdata  (reg_wdata),
   .reg_wr     (reg_wr),
   .reg_rd     (reg_rd),
   .reg_rdata  (reg_rdata),
   .sent_rx_in (sent_rx_in),
   .sent_tx_out(sent_tx_out),
   .sent_tx_oe (sent_tx_oe),
   .frame_done (frame_done)
);

//--- verif/snt_rx_model.sv
// receiver model: logs spacing of falling edges on the line in clocks
`timescale 1ns/10ps

module snt_rx_model
(
   input  wire logic core_clk,
   input  wire logic sent_line
);
   int   gaps[$];
   int   cnt = 0;
   logic prev_q = 1'b1;

   always @(posedge core_clk)
   begin
      if (prev_q && !sent_line)
      begin
         gaps.push_back(cnt);
         cnt = 1;
      end
      else
         cnt = cnt + 1;
      prev_q = sent_line;
   end
endmodule

//--- verif/tb.sv
// self-checking bench for the transmit engine
`timescale 1ns/10ps
`include "snt_defs.svh"

module tb;
   typedef struct {logic [15:0] ctl, tp, fp, dh, dl, st;} snt_row_s;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [2:0]  reg_addr = 3'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        sent_rx_in = 1'b1;
   logic [15:0] reg_rdata;
   logic        sent_tx_out;
   logic        sent_tx_oe;
   logic        frame_done;
   wire         sent_line;
   int          miscompares = 0;
   int          cmp_count = 0;
   int          done_cnt = 0;
   int          base;
   int          want[$];
   logic [15:0] rv;
   snt_row_s    rows[6] = '{
      '{16'h8001, 16'h0000, 16'h0000, 16'h3A00, 16'h0007, 16'h0001},
      '{16'h8186, 16'h0001, 16'h03E8, 16'h5123, 16'h456F, 16'h0001},
      '{16'h8183, 16'h0000, 16'hFFFF, 16'hF000, 16'h0000, 16'h0001},
      '{16'h8082, 16'h0002, 16'h0010, 16'h0FF0, 16'h000C, 16'h0001},
      '{16'h8580, 16'h0000, 16'h0000, 16'h1234, 16'h5678, 16'h0000},
      '{16'h8507, 16'h0001, 16'h0000, 16'h9876, 16'h5430, 16'h0000}};

   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) if (frame_done === 1'b1) done_cnt++;
   // line has a pull-up when released
   assign sent_line = sent_tx_oe ? sent_tx_out : 1'b1;

   snt_tx u_snt_tx (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sent_rx_in(sent_rx_in), .sent_tx_out(sent_tx_out), .sent_tx_oe(sent_tx_oe),
      .frame_done(frame_done));
   snt_rx_model u_snt_rx_model (.core_clk(core_clk), .sent_line(sent_line));

   // ----
   // helpers
   // ----
   task conclude;
      if (miscompares == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input logic [15:0] seen, input logic [15:0] expv);
      cmp_count++;
      if (seen !== expv)
      begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask

   task wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
   endtask

   task wait_done(input int n);
      int k;
      for (k = 0; done_cnt < n && k < 20000; k++) @(posedge core_clk);
      chk(16'(k == 20000), 16'h0000);
   endtask

   task rxp(input int t);
      sent_rx_in <= 1'b0;
      repeat (5) @(posedge core_clk);
      sent_rx_in <= 1'b1;
      repeat (t - 5) @(posedge core_clk);
   endtask

   // pulse lengths in ticks for one frame of a row
   task build(input snt_row_s r);
      logic [23:0] d;
      logic [3:0]  c;
      int          n;
      int          s;
      int          p;
      d = {r.dh[11:0], r.dl[15:4]};
      n = r.ctl[2:0] == 3'h0 ? 1 : (r.ctl[2:0] == 3'h7 ? 6 : int'(r.ctl[2:0]));
      c = 4'h5;
      want = {56, 12 + int'(r.dh[15:12])};
      for (int i = 0; i < n; i++) want.push_back(12 + int'(d[23-4*i -: 4]));
      for (int i = 0; i < 4*n+4; i++)
         c = {c[2:0], (i < 4*n) ? d[23-i] : 1'b0} ^ (c[3] ? 4'hD : 4'h0);
      if (!r.ctl[8]) c = r.dl[3:0];
      want.push_back(12 + int'(c));
      s = 0;
      foreach (want[i]) s += want[i];
      p = int'(r.fp);
      if (p > 2047) p = 2047;
      p = p - s;
      if (r.ctl[7]) want.push_back((r.ctl[10] || p < 12) ? 12 : p);
   endtask

   initial
   begin
      repeat (60000) @(posedge core_clk);
      miscompares++;
      conclude();
   end

   // ----
   // main sequence
   // ----
   initial
   begin
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      foreach (rows[k])
      begin
         wr(`SNT_OFS_TICK_PERIOD, rows[k].tp);
         wr(`SNT_OFS_FRAME_PERIOD, rows[k].fp);
         wr(`SNT_OFS_DATA_HIGH, rows[k].dh);
         wr(`SNT_OFS_DATA_LOW, rows[k].dl);
         build(rows[k]);
         u_snt_rx_model.gaps.delete();
         base = done_cnt;
         wr(`SNT_OFS_MAIN_CONTROL, rows[k].ctl);
         if (rows[k].ctl[10])
         begin
            wr(`SNT_OFS_LINK_STATUS, 16'h0001);
            rd(`SNT_OFS_LINK_STATUS, rv);
            chk({15'h0, rv[0]}, 16'h0001);
            wait_done(base + 1);
            wr(`SNT_OFS_LINK_STATUS, 16'h0001);
         end
         wait_done(base + 2);
         rd(`SNT_OFS_LINK_STATUS, rv);
         chk({15'h0, rv[0]}, rows[k].st);
         for (int i = 0; i < want.size() - int'(rows[k].ctl[10]); i++)
            chk(16'(u_snt_rx_model.gaps[i+1]), 16'(want[i] * (rows[k].tp + 1)));
         wr(`SNT_OFS_MAIN_CONTROL, 16'h0000);
      end
      // abort in mid-frame, then a second reset while sending
      wr(`SNT_OFS_MAIN_CONTROL, 16'h8001);
      repeat (20) @(posedge core_clk);
      wr(`SNT_OFS_MAIN_CONTROL, 16'h0000);
      repeat (2) @(negedge core_clk);
      chk({14'h0, sent_tx_oe, sent_tx_out}, 16'h0001);
      wr(`SNT_OFS_MAIN_CONTROL, 16'h8001);
      repeat (30) @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (5) @(negedge core_clk);
      chk({14'h0, sent_tx_oe, sent_tx_out}, 16'h0001);
      @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 8; a++)
      begin
         rd(3'(a), rv);
         chk(rv, 16'h0000);
      end
      wr(`SNT_OFS_MAIN_CONTROL, 16'hFFFF);
      rd(`SNT_OFS_MAIN_CONTROL, rv);
      chk(rv, 16'h8D87);
      wr(`SNT_OFS_LINK_STATUS, 16'h0001);
      rd(`SNT_OFS_LINK_STATUS, rv);
      chk({15'h0, rv[0]}, 16'h0000);
      @(posedge core_clk);
      rxp(56);
      rxp(56);
      rxp(20);
      rxp(20);
      rd(`SNT_OFS_LINK_STATUS, rv);
      chk({15'h0, rv[0]}, 16'h0001);
      wr(`SNT_OFS_MAIN_CONTROL, 16'h0000);
      conclude();
   end
endmodule
